// ==== src/fmc_core.sv ====
// Behaviour
// - subcommand 42h enables acoustic management at the level in sector count
// - acoustic enable and level survive soft and hard reset; only power-on reset restores them
// - acoustic level decoded into reserved, max, intermediate, min, retired, vendor
// - successful acoustic enable updates identify word 94 low byte
// - aborted acoustic subcommand keeps previous state and level
// - subcommand C2h disables acoustic management, optionally unimplemented
// - acoustic disable zeroes word 94 low byte and word 86 bit 9
// - AAh enables read look-ahead, 55h disables it
// - 5Dh/DDh enable/disable release interrupt
// - 5Eh/DEh enable/disable service interrupt
// - CCh enables revert to defaults, 66h keeps settings over soft reset
// - set max operation chosen from feature select value
// - set max address is F9h with feature 00h, no data
// - volatility bit one keeps new maximum, zero reverts to non-volatile one
// - drive/head bit 6 selects linear versus cylinder-head-sector form
// - completion returns maximum in force in address registers
// - success clears busy, fault, request, error and sets ready
// - abort if unsupported, over capacity, or no preceding read native max
// - second non-volatile set max since hard reset reports address not found
// - access beyond new maximum rejected with address not found
`timescale 1ns/10ps
module fmc_core
   import fmc_pkg::*;
#(
   parameter bit AAM_OFF_SUPPORTED = 1'b1
)(
   input  wire logic        pclk,          // bus clock
   input  wire logic        presetn,       // async reset, power-on
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [7:0]  paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   output logic             aam_en,        // acoustic management on
   output logic      [7:0]  aam_level,     // acoustic level
   output logic             look_ahead_en, // read look-ahead on
   output logic             rel_irq_en,    // release interrupt on
   output logic             svc_irq_en,    // service interrupt on
   output logic             revert_en,     // revert to defaults on
   output logic      [27:0] max_addr,      // maximum address in force
   output logic             max_is_lba     // maximum held as linear
);
   logic [7:0]  feat_r;
   logic [7:0]  cnt_r;
   logic [7:0]  sn_r;
   logic [7:0]  cl_r;
   logic [7:0]  ch_r;
   logic [7:0]  dh_r;
   logic [7:0]  err_r;
   logic [7:0]  stat_r;
   logic [7:0]  cmd_r;
   logic        aam_en_r;
   logic        rla_r;
   logic        rel_r;
   logic        svc_r;
   logic        rev_r;
   logic        lba_r;
   logic [7:0]  aam_lvl_r;
   logic [27:0] max_r;
   logic [27:0] nv_max_r;
   logic [27:0] cap_r;
   logic [27:0] acc_addr_r;
   logic        nv_used_r;
   logic        native_ok_r;
   logic        acc_address_not_found_r;
   fmc_state_t  state_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;

   wire acc_phase = psel & penable & ~pready_r;
   wire wr = acc_phase & pwrite;
   wire rd = acc_phase & ~pwrite;
   wire busy = state_r != FMC_IDLE;
   wire wr_cmd = wr & (paddr == OFF_COMMAND_CODE) & ~busy;
   wire wr_tf = wr & ~busy;
   // soft reset (control bit 0) and hard reset (control bit 1)
   wire soft_rst = wr & (paddr == OFF_CONTROL) & pwdata[0];
   wire hard_rst = wr & (paddr == OFF_CONTROL) & pwdata[1];
   wire acc_req = wr & (paddr == OFF_ACCESS);

   // acoustic level class code: 0 vendor 1 retired 2 min 3 mid 4 max 5 reserved
   wire [2:0] aam_class =
      (aam_lvl_r == AAM_RESERVED) ? 3'h5 :
      (aam_lvl_r == AAM_MAX_PERF) ? 3'h4 :
      (aam_lvl_r >  AAM_MIN_NOISE) ? 3'h3 :
      (aam_lvl_r == AAM_MIN_NOISE) ? 3'h2 :
      (aam_lvl_r == AAM_VENDOR) ? 3'h0 : 3'h1;

   wire [27:0] new_max = {dh_r[3:0], ch_r, cl_r, sn_r};
   wire        is_sf = cmd_r == CMD_SET_FEATURES;
   wire        is_sm = cmd_r == CMD_SET_MAX;
   wire        is_rn = cmd_r == CMD_READ_NATIVE;
   wire        sm_addr = is_sm & (feat_r == SM_ADDRESS);
   // set password, lock, unlock, freeze are not implemented here
   wire        sm_other = is_sm & (feat_r != SM_ADDRESS);
   wire        sf_known =
      (feat_r == SF_AAM_ON) | ((feat_r == SF_AAM_OFF) & AAM_OFF_SUPPORTED) |
      (feat_r == SF_RLA_ON) | (feat_r == SF_RLA_OFF) |
      (feat_r == SF_REL_ON) | (feat_r == SF_REL_OFF) |
      (feat_r == SF_SVC_ON) | (feat_r == SF_SVC_OFF) |
      (feat_r == SF_REV_ON) | (feat_r == SF_REV_OFF);
   wire        sm_abort = ~native_ok_r | (new_max > cap_r);
   // a set max with the volatility select bit set is the non-volatile kind
   wire        sm_address_not_found = cnt_r[VV_BIT] & nv_used_r;
   wire        do_abort = (is_sf & ~sf_known) | sm_other |
                          (sm_addr & sm_abort) | ~(is_sf | is_sm | is_rn);
   wire        exec = state_r == FMC_EXEC;
   wire        ok = exec & ~do_abort & ~(sm_addr & sm_address_not_found);
   wire        sf_ok = ok & is_sf;
   wire        sm_ok = ok & sm_addr;
   wire [27:0] ret_max = sm_ok ? new_max : max_r;
   wire [15:0] id_w94 = aam_en_r ? {8'h00, aam_lvl_r} : 16'h0000;
   wire [15:0] id_w86 = 16'(aam_en_r) << AAM_EN_BIT;

   wire [31:0] rd_mux =
      (paddr == OFF_SECTOR_COUNT)   ? {24'h0, cnt_r} :
      (paddr == OFF_SECTOR_NUMBER)  ? {24'h0, sn_r} :
      (paddr == OFF_CYLINDER_LOW)   ? {24'h0, cl_r} :
      (paddr == OFF_CYLINDER_HIGH)  ? {24'h0, ch_r} :
      (paddr == OFF_DRIVE_AND_HEAD) ? {24'h0, dh_r} :
      (paddr == OFF_ERROR)          ? {24'h0, err_r} :
      (paddr == OFF_STATUS)         ? {24'h0, stat_r} :
      (paddr == OFF_SETTINGS)       ? {16'h0, aam_class, rev_r, svc_r, rel_r,
                                       rla_r, aam_en_r, aam_lvl_r} :
      (paddr == OFF_ACCESS)         ? {31'h0, acc_address_not_found_r} :
      (paddr == OFF_ID_WORDS)       ? {id_w86, id_w94} :
      (paddr == OFF_MAX_ADDR)       ? {3'h0, lba_r, max_r} :
      (paddr == OFF_CAPACITY)       ? {4'h0, cap_r} : 32'h0;
   wire addr_ok = (paddr <= OFF_CAPACITY) & (paddr[1:0] == 2'b00);

   // apb slave: one wait state, answer in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end
      else
      begin
         pready_r  <= acc_phase;
         pslverr_r <= acc_phase & ~addr_ok;
         prdata_r  <= rd ? rd_mux : 32'h0;
      end
   end

   // command sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= FMC_IDLE;
      else
      begin
         case (state_r)
            FMC_IDLE: state_r <= wr_cmd ? FMC_EXEC : FMC_IDLE;
            FMC_EXEC: state_r <= FMC_DONE;
            FMC_DONE: state_r <= FMC_IDLE;
            default:  state_r <= FMC_IDLE;
         endcase
      end
   end

   // task file inputs and outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         feat_r <= 8'h00;
         cnt_r  <= 8'h00;
         sn_r   <= 8'h00;
         cl_r   <= 8'h00;
         ch_r   <= 8'h00;
         dh_r   <= 8'h00;
         cmd_r  <= 8'h00;
      end
      else if (exec & (sm_ok | (is_rn & ~do_abort)))
      begin
         sn_r <= ret_max[7:0];
         cl_r <= ret_max[15:8];
         ch_r <= ret_max[23:16];
         dh_r <= {dh_r[7:4], ret_max[27:24]};
      end
      else if (wr_tf)
      begin
         if (paddr == OFF_FEATURE_SELECT) feat_r <= pwdata[7:0];
         if (paddr == OFF_SECTOR_COUNT)   cnt_r  <= pwdata[7:0];
         if (paddr == OFF_SECTOR_NUMBER)  sn_r   <= pwdata[7:0];
         if (paddr == OFF_CYLINDER_LOW)   cl_r   <= pwdata[7:0];
         if (paddr == OFF_CYLINDER_HIGH)  ch_r   <= pwdata[7:0];
         if (paddr == OFF_DRIVE_AND_HEAD) dh_r   <= pwdata[7:0];
         if (paddr == OFF_COMMAND_CODE)   cmd_r  <= pwdata[7:0];
      end
   end

   // status and error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_r <= RST_STATUS;
         err_r  <= 8'h00;
      end
      else if (wr_cmd)
      begin
         stat_r <= 8'h00;
         stat_r[ST_BSY] <= 1'b1;
         err_r  <= 8'h00;
      end
      else if (exec)
      begin
         err_r <= 8'h00;
         err_r[ERR_COMMAND_ABORTED] <= do_abort;
         err_r[ERR_ADDRESS_NOT_FOUND] <= ~do_abort & sm_addr & sm_address_not_found;
         stat_r <= 8'h00;
         stat_r[ST_DRIVE_READY_FLAG] <= 1'b1;
         stat_r[ST_ERR]  <= ~ok;
      end
   end

   // acoustic state is never touched by any reset kind except power-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aam_en_r  <= 1'b0;
         aam_lvl_r <= RST_AAM_LVL;
      end
      else if (sf_ok & (feat_r == SF_AAM_ON))
      begin
         aam_en_r  <= 1'b1;
         aam_lvl_r <= cnt_r;
      end
      else if (sf_ok & (feat_r == SF_AAM_OFF))
         aam_en_r <= 1'b0;
   end

   // enables hold until their subcommand or a hard reset; all but revert also return to defaults on a soft reset while revert is on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rla_r <= 1'b1;
         rel_r <= 1'b0;
         svc_r <= 1'b0;
         rev_r <= 1'b1;
      end
      else if (hard_rst | (soft_rst & rev_r))
      begin
         rla_r <= 1'b1;
         rel_r <= 1'b0;
         svc_r <= 1'b0;
         if (hard_rst) rev_r <= 1'b1;
      end
      else if (sf_ok)
      begin
         if (feat_r == SF_RLA_ON)  rla_r <= 1'b1;
         if (feat_r == SF_RLA_OFF) rla_r <= 1'b0;
         if (feat_r == SF_REL_ON)  rel_r <= 1'b1;
         if (feat_r == SF_REL_OFF) rel_r <= 1'b0;
         if (feat_r == SF_SVC_ON)  svc_r <= 1'b1;
         if (feat_r == SF_SVC_OFF) svc_r <= 1'b0;
         if (feat_r == SF_REV_ON)  rev_r <= 1'b1;
         if (feat_r == SF_REV_OFF) rev_r <= 1'b0;
      end
   end

   // maximum address state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         max_r       <= RST_MAX;
         nv_max_r    <= RST_MAX;
         cap_r       <= RST_MAX;
         lba_r       <= 1'b1;
         nv_used_r   <= 1'b0;
         native_ok_r <= 1'b0;
      end
      else
      begin
         if (wr & (paddr == OFF_CAPACITY) & ~busy)
            cap_r <= pwdata[27:0];
         if (exec)
         begin
            native_ok_r <= is_rn & ~do_abort;
         end
         if (hard_rst)
         begin
            max_r     <= nv_max_r;
            nv_used_r <= 1'b0;
         end
         // a completing set max wins over a hard reset in the same cycle
         if (sm_ok)
         begin
            max_r <= new_max;
            lba_r <= dh_r[LBA_BIT];
            if (cnt_r[VV_BIT])
            begin
               nv_used_r <= 1'b1;
               nv_max_r  <= new_max;
            end
         end
      end
   end

   // media access check against the maximum in force
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_addr_r <= 28'h0;
         acc_address_not_found_r <= 1'b0;
      end
      else
      begin
         if (acc_req)
            acc_addr_r <= pwdata[27:0];
         // rechecked every cycle so a new maximum applies one cycle after it takes force
         acc_address_not_found_r <= acc_addr_r > max_r;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign aam_en        = aam_en_r;
   assign aam_level     = aam_lvl_r;
   assign look_ahead_en = rla_r;
   assign rel_irq_en    = rel_r;
   assign svc_irq_en    = svc_r;
   assign revert_en     = rev_r;
   assign max_addr      = max_r;
   assign max_is_lba    = lba_r;
endmodule

// ==== src/fmc_pkg.sv ====
package fmc_pkg;
   // register byte offsets (one aligned word each)
   localparam logic [7:0] OFF_FEATURE_SELECT = 8'h00;
   localparam logic [7:0] OFF_SECTOR_COUNT   = 8'h04;
   localparam logic [7:0] OFF_SECTOR_NUMBER  = 8'h08;
   localparam logic [7:0] OFF_CYLINDER_LOW   = 8'h0c;
   localparam logic [7:0] OFF_CYLINDER_HIGH  = 8'h10;
   localparam logic [7:0] OFF_DRIVE_AND_HEAD = 8'h14;
   localparam logic [7:0] OFF_COMMAND_CODE   = 8'h18;
   localparam logic [7:0] OFF_ERROR          = 8'h1c;
   localparam logic [7:0] OFF_STATUS         = 8'h20;
   localparam logic [7:0] OFF_SETTINGS       = 8'h24;
   localparam logic [7:0] OFF_CONTROL        = 8'h28;
   localparam logic [7:0] OFF_ACCESS         = 8'h2c;
   localparam logic [7:0] OFF_ID_WORDS       = 8'h30;
   localparam logic [7:0] OFF_MAX_ADDR       = 8'h34;
   localparam logic [7:0] OFF_CAPACITY       = 8'h38;
   // command codes
   localparam logic [7:0] CMD_SET_FEATURES   = 8'hef;
   localparam logic [7:0] CMD_SET_MAX        = 8'hf9;
   localparam logic [7:0] CMD_READ_NATIVE    = 8'hf8;
   // set features subcommands
   localparam logic [7:0] SF_AAM_ON          = 8'h42;
   localparam logic [7:0] SF_AAM_OFF         = 8'hc2;
   localparam logic [7:0] SF_RLA_ON          = 8'haa;
   localparam logic [7:0] SF_RLA_OFF         = 8'h55;
   localparam logic [7:0] SF_REL_ON          = 8'h5d;
   localparam logic [7:0] SF_REL_OFF         = 8'hdd;
   localparam logic [7:0] SF_SVC_ON          = 8'h5e;
   localparam logic [7:0] SF_SVC_OFF         = 8'hde;
   localparam logic [7:0] SF_REV_ON          = 8'hcc;
   localparam logic [7:0] SF_REV_OFF         = 8'h66;
   // acoustic level classes
   localparam logic [7:0] AAM_RESERVED       = 8'hff;
   localparam logic [7:0] AAM_MAX_PERF       = 8'hfe;
   localparam logic [7:0] AAM_MIN_NOISE      = 8'h80;
   localparam logic [7:0] AAM_VENDOR         = 8'h00;
   // set max feature values
   localparam logic [7:0] SM_ADDRESS         = 8'h00;
   localparam logic [7:0] SM_FREEZE          = 8'h04;
   // field positions
   localparam int VV_BIT      = 0;
   localparam int LBA_BIT     = 6;
   localparam int DRV_BIT     = 4;
   localparam int AAM_EN_BIT  = 9;
   localparam int ERR_ADDRESS_NOT_FOUND    = 4;
   localparam int ERR_COMMAND_ABORTED    = 2;
   localparam int ST_BSY      = 7;
   localparam int ST_DRIVE_READY_FLAG     = 6;
   localparam int ST_DF       = 5;
   localparam int ST_DRQ      = 3;
   localparam int ST_ERR      = 0;
   // reset values
   localparam logic [7:0]  RST_STATUS  = 8'h40;
   localparam logic [27:0] RST_MAX     = 28'hfffffff;
   localparam logic [7:0]  RST_AAM_LVL = 8'hfe;
   typedef enum logic [1:0] {
      FMC_IDLE = 2'b00,
      FMC_EXEC = 2'b01,
      FMC_DONE = 2'b11
   } fmc_state_t;
endpackage

// ==== verif/fmc_core_properties.sv ====
`timescale 1ns/10ps
module fmc_core_chk
   import fmc_pkg::*;
(
   input wire logic        pclk,          // clk
   input wire logic        presetn,       // rst
   input wire logic        psel,          // sel
   input wire logic        penable,       // en
   input wire logic        pwrite,        // dir
   input wire logic [7:0]  paddr,         // addr
   input wire logic [31:0] pwdata,        // wdata
   input wire logic [31:0] prdata,        // rdata
   input wire logic        pready,        // ready
   input wire logic        pslverr,       // err
   input wire logic        aam_en,        // aam on
   input wire logic [7:0]  aam_level,     // level
   input wire logic        look_ahead_en, // rla
   input wire logic        rel_irq_en,    // rel
   input wire logic        svc_irq_en,    // svc
   input wire logic        revert_en,     // rev
   input wire logic [27:0] max_addr,      // max
   input wire logic        max_is_lba     // lba
);
   logic [7:0] feat_r;
   logic [7:0] cnt_r;
   logic [2:0] age_r;
   wire logic  tk  = psel && penable && pwrite && !pready;
   wire logic  cw  = tk && paddr == OFF_COMMAND_CODE;
   wire logic  go  = cw && pwdata[7:0] == CMD_SET_FEATURES;
   wire logic  ctl = tk && paddr == OFF_CONTROL;
   // age of the last command or control write, saturating
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         feat_r <= 8'h00;
         cnt_r  <= 8'h00;
         age_r  <= 3'h7;
      end
      else
      begin
         if (tk && paddr == OFF_FEATURE_SELECT)
            feat_r <= pwdata[7:0];
         if (tk && paddr == OFF_SECTOR_COUNT)
            cnt_r <= pwdata[7:0];
         age_r <= (cw || ctl) ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
      end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   aam_enable_a: assert property (go && feat_r == SF_AAM_ON && cnt_r != 8'h00
      && cnt_r != 8'hff |-> ##[1:3] aam_en && aam_level == cnt_r) else $error("aam enable");
   aam_keep_a: assert property (ctl |=> $stable({aam_en, aam_level})[*3])
      else $error("aam lost on reset");
   aam_off_a: assert property (go && feat_r == SF_AAM_OFF |-> ##[1:3] !aam_en)
      else $error("aam disable");
   rla_set_a: assert property (go && (feat_r == SF_RLA_ON || feat_r == SF_RLA_OFF)
      |-> ##[1:3] look_ahead_en == (feat_r == SF_RLA_ON)) else $error("look-ahead");
   irq_set_a: assert property (go && (feat_r == SF_REL_ON || feat_r == SF_SVC_OFF)
      |-> ##[1:3] (rel_irq_en || feat_r == SF_SVC_OFF) && !(svc_irq_en && feat_r == SF_SVC_OFF))
      else $error("irq enable");
   revert_set_a: assert property (go && (feat_r == SF_REV_ON || feat_r == SF_REV_OFF)
      |-> ##[1:3] revert_en == (feat_r == SF_REV_ON)) else $error("revert");
   settings_hold_a: assert property ($changed({look_ahead_en, rel_irq_en, svc_irq_en,
      revert_en, aam_en, aam_level}) |-> age_r < 3'h4) else $error("setting drift");
   max_hold_a: assert property ($changed({max_is_lba, max_addr}) |-> age_r < 3'h4)
      else $error("max drift");
   cover property (go && feat_r == SF_AAM_ON);
   cover property (ctl && pwdata[0]);
   cover property ($changed(max_addr));
endmodule
bind fmc_core fmc_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .aam_en(aam_en), .aam_level(aam_level),
   .look_ahead_en(look_ahead_en), .rel_irq_en(rel_irq_en), .svc_irq_en(svc_irq_en),
   .revert_en(revert_en), .max_addr(max_addr), .max_is_lba(max_is_lba));

// ==== verif/fmc_core_tb_top.sv ====
`timescale 1ns/10ps
module fmc_core_tb_top import fmc_pkg::*;;
   logic        pclk;
   logic        presetn;
   logic        psel, penable, pwrite, pready, pslverr, hung, e;
   logic        aam_en, look_ahead_en, rel_irq_en, svc_irq_en, revert_en, max_is_lba;
   logic [7:0]  paddr, aam_level, st;
   logic [31:0] pwdata, prdata, q, m;
   logic [27:0] max_addr;
   wire  [31:0] set_bits = {19'h0, aam_en, aam_level, look_ahead_en, rel_irq_en,
                            svc_irq_en, revert_en};
   int          bad_count = 0;
   int          n_compared = 0;
   logic [7:0]  sub [13] = '{8'h55, 8'h5d, 8'h5e, 8'h00, 8'h55, 8'h5d, 8'h66, 8'h00, 8'haa,
                             8'hdd, 8'h5e, 8'hde, 8'hcc};
   logic [3:0]  flg [13] = '{4'h1, 4'h5, 4'h7, 4'h9, 4'h1, 4'h5, 4'h4, 4'h4, 4'hc, 4'h8, 4'ha,
                             4'h8, 4'h9};
   logic [7:0]  lvl [4] = '{8'hfe, 8'h90, 8'h80, 8'h10};
   logic [7:0]  tfa [4] = '{OFF_DRIVE_AND_HEAD, OFF_CYLINDER_HIGH, OFF_CYLINDER_LOW,
                            OFF_SECTOR_NUMBER};
   fmc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .aam_en(aam_en), .aam_level(aam_level),
      .look_ahead_en(look_ahead_en), .rel_irq_en(rel_irq_en), .svc_irq_en(svc_irq_en),
      .revert_en(revert_en), .max_addr(max_addr), .max_is_lba(max_is_lba));
   fmc_host_model u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .hung(hung));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task ck(string n, logic [31:0] x, logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", n, x, g);
      end
   endtask
   task end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge hung)
   begin
      bad_count++;
      end_of_test();
   end
   initial
   begin
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      ck("reset", 32'h0fe9, set_bits);
      ck("reset max", 32'h1fffffff, {3'h0, max_is_lba, max_addr});
      u_host.rd(OFF_STATUS, q, e);
      ck("status", 32'h40, q);
      u_host.rd(8'h3c, q, e);
      ck("unmapped", 32'h1, {q[30:0], e});
      foreach (sub[i])
      begin
         if (sub[i] == 8'h00)
            u_host.wr(OFF_CONTROL, 32'h1);
         else
            u_host.cmd(sub[i], CMD_SET_FEATURES, st);
         ck("flags", {28'h0, flg[i]}, {28'h0, set_bits[3:0]});
      end
      foreach (lvl[i])
      begin
         u_host.aam_on(lvl[i], st);
         ck("aam", {23'h0, 1'b1, lvl[i]}, {23'h0, aam_en, aam_level});
         u_host.rd(OFF_SETTINGS, q, e);
         ck("class", 32'h4 - i, {29'h0, q[15:13]});
         u_host.rd(OFF_ID_WORDS, q, e);
         ck("id words", {8'h02, 16'h0, lvl[i]}, q & 32'h020000ff);
      end
      u_host.cmd(8'h99, CMD_SET_FEATURES, st);
      ck("abort status", 32'h41, {24'h0, st});
      u_host.rd(OFF_ERROR, q, e);
      ck("abort error", 32'h4, q);
      u_host.wr(OFF_CONTROL, 32'h2);
      u_host.wr(OFF_CONTROL, 32'h1);
      ck("aam kept", 32'h110, {23'h0, aam_en, aam_level});
      u_host.cmd(SF_AAM_OFF, CMD_SET_FEATURES, st);
      u_host.rd(OFF_ID_WORDS, q, e);
      ck("aam off", 32'h0, (q & 32'h020000ff) | {23'h0, aam_en, 8'h0});
      u_host.cmd(SM_ADDRESS, CMD_SET_MAX, st);
      ck("no native", 32'h41, {24'h0, st});
      u_host.cmd(8'h00, CMD_READ_NATIVE, st);
      u_host.cmd(8'h05, CMD_SET_MAX, st);
      ck("reserved", 32'h41, {24'h0, st});
      u_host.set_max(28'h0123456, 1'b1, 1'b1, st);
      ck("max status", 32'h40, {24'h0, st});
      ck("max", 32'h10123456, {3'h0, max_is_lba, max_addr});
      foreach (tfa[i])
      begin
         u_host.rd(tfa[i], q, e);
         m = {m[23:0], q[7:0]};
      end
      ck("task file", 32'h0123456, {4'h0, m[27:0]});
      u_host.wr(OFF_ACCESS, 32'h0123457);
      u_host.rd(OFF_ACCESS, q, e);
      ck("beyond max", 32'h1, {31'h0, q[0]});
      u_host.wr(OFF_ACCESS, 32'h0123456);
      u_host.rd(OFF_ACCESS, q, e);
      ck("at max", 32'h0, {31'h0, q[0]});
      u_host.set_max(28'h0000100, 1'b1, 1'b0, st);
      ck("volatile", 32'h10000100, {3'h0, max_is_lba, max_addr});
      u_host.wr(OFF_CONTROL, 32'h2);
      ck("hard reset", 32'h10123456, {3'h0, max_is_lba, max_addr});
      u_host.wr(OFF_CAPACITY, 32'h1000);
      u_host.set_max(28'h0002000, 1'b1, 1'b0, st);
      u_host.rd(OFF_ERROR, q, e);
      ck("capacity", 32'h4, q);
      u_host.wr(OFF_CAPACITY, 32'hfffffff);
      u_host.set_max(28'h0002003, 1'b0, 1'b1, st);
      ck("chs", 32'h00002003, {3'h0, max_is_lba, max_addr});
      u_host.set_max(28'h0000200, 1'b1, 1'b1, st);
      u_host.rd(OFF_ERROR, q, e);
      ck("second", 32'h10, q);
      ck("max kept", 32'h00002003, {3'h0, max_is_lba, max_addr});
      end_of_test();
   end
endmodule

// ==== verif/fmc_host_model.sv ====
`timescale 1ns/10ps
module fmc_host_model
   import fmc_pkg::*;
(
   input  wire logic        pclk,    // clk
   input  wire logic [31:0] prdata,  // rdata
   input  wire logic        pready,  // ready
   input  wire logic        pslverr, // err
   output logic             psel,    // sel
   output logic             penable, // en
   output logic             pwrite,  // dir
   output logic      [7:0]  paddr,   // addr
   output logic      [31:0] pwdata,  // wdata
   output logic             hung     // no answer
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hung = 1'b0;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      hung = hung | (n == 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines do not keep the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, a, d, q, e);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      xfer(1'b0, a, 32'h0, q, e);
   endtask
   task cmd(input logic [7:0] f, input logic [7:0] c, output logic [7:0] st);
      logic [31:0] q;
      logic        e;
      int          n;
      wr(OFF_FEATURE_SELECT, {24'h0, f});
      wr(OFF_COMMAND_CODE, {24'h0, c});
      for (n = 0; n < 8; n++)
      begin
         rd(OFF_STATUS, q, e);
         if (q[ST_BSY] === 1'b0)
            break;
      end
      hung = hung | (n == 8);
      st = q[7:0];
   endtask
   task aam_on(input logic [7:0] lvl, output logic [7:0] st);
      wr(OFF_SECTOR_COUNT, {24'h0, lvl});
      cmd(SF_AAM_ON, CMD_SET_FEATURES, st);
   endtask
   task set_max(input logic [27:0] m, input logic l, input logic vv, output logic [7:0] st);
      cmd(8'h00, CMD_READ_NATIVE, st);
      wr(OFF_SECTOR_COUNT, {31'h0, vv});
      wr(OFF_SECTOR_NUMBER, {24'h0, m[7:0]});
      wr(OFF_CYLINDER_LOW, {24'h0, m[15:8]});
      wr(OFF_CYLINDER_HIGH, {24'h0, m[23:16]});
      wr(OFF_DRIVE_AND_HEAD, {24'h0, 1'b1, l, 2'b10, m[27:24]});
      cmd(SM_ADDRESS, CMD_SET_MAX, st);
   endtask
endmodule
